// ### rtl/cfa_core.sv
// Core fetch, two-word decode and banked data addressing
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
// How it works
// [RULE1] Byte-addressed program memory, words on even bytes
// [RULE2] PC steps by two, bit zero reads zero
// [RULE3] Absolute jump loads word address into PC[20:1]
// [RULE4] Branch byte displacement is twice encoded offset
// [RULE5] Second words carry 1111 tag, 12-bit literal
// [RULE6] Lone tagged word executes as a no-op
// [RULE7] Data addresses twelve bits, sixteen 256-byte banks
// [RULE8] Unimplemented data locations read as zero
// [RULE9] Access bank reaches bank zero/top without pointer
// [RULE10] Bank pointer gives upper four, operand lower eight
// [RULE11] Bank pointer upper four bits read zero
// [RULE12] Literal load instruction writes bank pointer
// [RULE13] Unimplemented bank writes dropped, reads give zero
// [RULE14] Flags update even for unimplemented bank targets
// [RULE15] Full address move ignores bank pointer entirely
// [RULE16] Other instructions complete address from pointer/map
// [RULE17] Bank 15 offset F9h is PC low byte
// [RULE18] Access select zero uses map, one uses pointer
// [RULE19] Map 00h-5Fh bank zero, 60h-FFh bank fifteen
// [RULE20] Program counter is 21 bits wide
module cfa_core
   import cfa_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [PC_W-1:0] pm_addr,
   input wire logic [IW-1:0] pm_rdata
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   cfa_phase_e phase;            // Current quadrature phase
   logic run;                    // Software run enable
   // [RULE20] 21-bit counter
   logic [PC_W-1:0] pc;          // Next fetch address
   logic [IW-1:0] fetch_word;    // Word latched at Q4
   logic fetch_valid;            // Latched word not squashed
   logic [IW-1:0] ir;            // Executing word
   logic ir_valid;               // Executing word is live
   cfa_pend_e pend;              // First word waiting for its second
   logic [7:0] lit_lo;           // Low literal of a first word
   logic [7:0] hold;             // Source byte of a full address move
   logic [BANK_W-1:0] bank_pointer; // Only the low nibble exists
   logic [7:0] wreg;             // Working register
   logic [2:0] flags;            // Carry, zero, negative
   logic [7:0] opnd;             // Operand read at Q2, caught at Q3
   logic [DA_W-1:0] last_daddr;  // Last data address used
   logic [7:0] ram_q;            // RAM read data

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   cfa_op_e opk;                 // Decoded operation
   logic [DA_W-1:0] daddr;       // Data address of this word
   logic uses_data;              // Word touches data memory

   // Banked or access-bank address from an 8-bit operand
   function automatic logic [DA_W-1:0] f_addr(input logic acc_sel,
      input logic [OFS_W-1:0] ofs, input logic [BANK_W-1:0] bp);
      begin
         // [RULE18] access select
         if (acc_sel)
         begin
            // [RULE10] pointer plus offset
            f_addr = {bp, ofs};
         end
         // [RULE9] fast access bank
         // [RULE19] split at 60h
         else if (ofs < ACCESS_SPLIT)
         begin
            f_addr = {BANK_LOW, ofs};
         end
         else
         begin
            f_addr = {BANK_TOP, ofs};
         end
      end
   endfunction

   // Classify the executing word
   always_comb
   begin
      opk = OPK_NOP;
      daddr = '0;
      uses_data = 1'b0;
      if (!ir_valid)
      begin
         opk = OPK_NOP;          // Flushed slot
      end
      // [RULE5] tagged second word
      else if (ir[15:12] == TWO_WORD_TAG)
      begin
         // [RULE6] only after its first word
         unique case (pend)
            PEND_GOTO: opk = OPK_GOTO2;
            PEND_FULL_MOVE:
            begin
               opk = OPK_FULL_MOVE2;
               // [RULE15] full destination address
               daddr = ir[DA_W-1:0];
               uses_data = 1'b1;
            end
            PEND_LFSR: opk = OPK_LFSR2;
            PEND_NONE: opk = OPK_NOP;
         endcase
      end
      else if (ir[15:8] == OP_GOTO || ir[15:9] == OP_CALL)
      begin
         opk = OPK_GOTO1;        // Call shares the jump path here
      end
      else if (ir[15:12] == OP_FULL_MOVE)
      begin
         opk = OPK_FULL_MOVE1;
         // [RULE15] full source address
         daddr = ir[DA_W-1:0];
         uses_data = 1'b1;
      end
      else if (ir[15:6] == OP_LFSR)
      begin
         opk = OPK_LFSR1;
      end
      else if (ir[15:11] == OP_BRA)
      begin
         opk = OPK_BRA;
      end
      else if (ir[15:4] == OP_BANK_LIT)
      begin
         opk = OPK_BANK_LIT;
      end
      else if (ir[15:8] == OP_MOVLW)
      begin
         opk = OPK_MOVLW;
      end
      else if (ir[15:10] == OP_ADDWF)
      begin
         opk = OPK_ADDWF;
         // [RULE16] low byte completed
         daddr = f_addr(ir[8], ir[7:0], bank_pointer);
         uses_data = 1'b1;
      end
      else if (ir[15:9] == OP_MOVWF)
      begin
         opk = OPK_MOVWF;
         // [RULE16] low byte completed
         daddr = f_addr(ir[8], ir[7:0], bank_pointer);
         uses_data = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Data path
   // ----------------------------------------------------------------
   logic [8:0] sum;              // Add with carry out
   logic [7:0] result;           // Byte produced at Q4
   logic dm_hit;                 // Address lands in backed RAM
   cfa_dm_req_s wr;              // Write request at Q4
   logic [7:0] rd_val;           // Read value before capture
   logic [PC_W-1:0] bra_disp;    // Branch byte displacement

   // [RULE7] bank number is the top nibble
   assign dm_hit = (daddr[DA_W-1:OFS_W] < DM_BANKS);
   assign sum = {1'b0, opnd} + {1'b0, wreg};
   // [RULE4] offset counts words
   assign bra_disp = {{(PC_W-12){ir[10]}}, ir[10:0], 1'b0};

   // Result byte and destination
   always_comb
   begin
      result = 8'h00;
      wr = '0;
      wr.addr = daddr;
      unique case (opk)
         OPK_ADDWF:
         begin
            result = sum[7:0];
            wr.we = ir[9];       // Destination file when d is set
         end
         OPK_MOVWF:
         begin
            result = wreg;
            wr.we = 1'b1;
         end
         OPK_FULL_MOVE2:
         begin
            result = hold;
            wr.we = 1'b1;
         end
         default:
         begin
            result = 8'h00;
         end
      endcase
      wr.wdata = result;
      wr.we = wr.we & (phase == PH_Q4) & run;
   end

   // Read mux: RAM or a core register, zero elsewhere
   always_comb
   begin
      // [RULE8] zero by default
      rd_val = 8'h00;
      if (dm_hit)
      begin
         rd_val = ram_q;
      end
      else
      begin
         // [RULE13] missing banks read zero
         unique case (daddr)
            // [RULE17] program counter low byte
            ADDR_PCL: rd_val = pc[7:0];
            // [RULE11] upper nibble reads zero
            ADDR_BANK: rd_val = {4'h0, bank_pointer};
            ADDR_WREG: rd_val = wreg;
            ADDR_FLAGS: rd_val = {5'h00, flags};
            default: rd_val = 8'h00;
         endcase
      end
   end

   // RAM; address held Q2..Q4 so read at Q2, write at Q4
   cfa_dmem u_dmem (
      .pclk(pclk),
      .presetn(presetn),
      // [RULE13] only backed banks write
      .we(wr.we & dm_hit),
      .addr(daddr[DM_AW-1:0]),
      .wdata(wr.wdata),
      .rdata(ram_q)
   );

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   logic adv;                    // Phase advances this cycle
   logic pcl_wr;                 // Data write hits the PC low byte
   logic jump;                   // PC reloaded at Q4
   assign adv = run;
   assign pcl_wr = wr.we & (wr.addr == ADDR_PCL);
   assign jump = (phase == PH_Q4) & run &
      (opk == OPK_GOTO2 || opk == OPK_BRA || pcl_wr);

   // Quadrature phase divider
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase <= PH_Q1;
      end
      else if (adv)
      begin
         phase <= cfa_phase_e'(phase + 2'b01);
      end
   end

   // Program counter: step at Q1, reload at Q4
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pc <= PC_RESET;
      end
      else if (jump)
      begin
         if (opk == OPK_GOTO2)
         begin
            // [RULE3] word address to PC[20:1]
            pc <= {ir[11:0], lit_lo, 1'b0};
         end
         else if (opk == OPK_BRA)
         begin
            // [RULE4] twice the offset
            pc <= pc + bra_disp;
         end
         else
         begin
            // [RULE17] data write moves PC
            // [RULE2] bit zero kept clear
            pc <= {pc[PC_W-1:8], wr.wdata[7:1], 1'b0};
         end
      end
      else if (adv && phase == PH_Q1 && fetch_valid)
      begin
         // [RULE2] step of one word
         // [RULE1] even byte addresses only
         pc <= pc + PC_STEP;
      end
   end

   // Program memory address follows the counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pm_addr <= PC_RESET;
      end
      else
      begin
         pm_addr <= pc;
      end
   end

   // Fetch latch at Q4; a reload squashes the stale word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fetch_word <= '0;
         fetch_valid <= 1'b0;
      end
      else if (adv && phase == PH_Q4)
      begin
         fetch_word <= pm_rdata;
         fetch_valid <= ~jump;
      end
   end

   // Instruction register loads at Q1
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ir <= '0;
         ir_valid <= 1'b0;
      end
      else if (adv && phase == PH_Q1)
      begin
         ir <= fetch_word;
         ir_valid <= fetch_valid;
      end
   end

   // Operand capture at Q3, one cycle after the RAM read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         opnd <= 8'h00;
         last_daddr <= '0;
      end
      else if (adv && phase == PH_Q3)
      begin
         opnd <= rd_val;
         if (uses_data)
         begin
            last_daddr <= daddr;
         end
      end
   end

   // Two-word bookkeeping: any other word closes the pair
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pend <= PEND_NONE;
         lit_lo <= 8'h00;
         hold <= 8'h00;
      end
      else if (adv && phase == PH_Q4)
      begin
         lit_lo <= ir[7:0];
         hold <= opnd;
         unique case (opk)
            OPK_GOTO1: pend <= PEND_GOTO;
            OPK_FULL_MOVE1: pend <= PEND_FULL_MOVE;
            OPK_LFSR1: pend <= PEND_LFSR;
            default: pend <= PEND_NONE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic apb_acc;                // Access phase present
   logic apb_wr;                 // Write commits this edge
   logic apb_map;                // Address is decoded
   logic [31:0] apb_rd;          // Read mux
   assign apb_acc = psel & penable;
   assign apb_wr = apb_acc & pready & pwrite & ~pslverr;

   // Register read mux and decode
   always_comb
   begin
      apb_map = 1'b1;
      unique case (paddr)
         REG_CTRL: apb_rd = {31'h0, run};
         REG_PC: apb_rd = {11'h000, pc};
         // [RULE11] upper bits read zero
         REG_BANK: apb_rd = {28'h0, bank_pointer};
         REG_WREG: apb_rd = {24'h0, wreg};
         REG_FLAGS: apb_rd = {29'h0, flags};
         REG_DADDR: apb_rd = {20'h0, last_daddr};
         default:
         begin
            apb_rd = 32'h0;
            apb_map = 1'b0;
         end
      endcase
   end

   // One wait state: answer in the second access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end
      else if (apb_acc && !pready)
      begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0 : apb_rd;
         pslverr <= ~apb_map;
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Run control
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run <= CTRL_RUN_RESET;
      end
      else if (apb_wr && paddr == REG_CTRL)
      begin
         run <= pwdata[CTRL_RUN];
      end
   end

   // ----------------------------------------------------------------
   // Architectural registers
   // ----------------------------------------------------------------
   // Bank pointer: core wins over a same-cycle bus write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bank_pointer <= '0;
      end
      else if (opk == OPK_BANK_LIT && phase == PH_Q4 && run)
      begin
         // [RULE12] literal load
         // [RULE11] upper bits dropped
         bank_pointer <= ir[BANK_W-1:0];
      end
      else if (wr.we && wr.addr == ADDR_BANK)
      begin
         bank_pointer <= wr.wdata[BANK_W-1:0];
      end
      else if (apb_wr && paddr == REG_BANK)
      begin
         bank_pointer <= pwdata[BANK_W-1:0];
      end
   end

   // Working register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wreg <= 8'h00;
      end
      else if (phase == PH_Q4 && run && opk == OPK_MOVLW)
      begin
         wreg <= ir[7:0];
      end
      else if (phase == PH_Q4 && run && opk == OPK_ADDWF && !ir[9])
      begin
         wreg <= result;
      end
      else if (wr.we && wr.addr == ADDR_WREG)
      begin
         wreg <= wr.wdata;
      end
      else if (apb_wr && paddr == REG_WREG)
      begin
         wreg <= pwdata[7:0];
      end
   end

   // Flags: the add always updates them, whatever its target
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags <= 3'h0;
      end
      else if (phase == PH_Q4 && run && opk == OPK_ADDWF)
      begin
         // [RULE14] flags as if successful
         flags[FLAG_C] <= sum[8];
         flags[FLAG_Z] <= (sum[7:0] == 8'h00);
         flags[FLAG_N] <= sum[7];
      end
      else if (wr.we && wr.addr == ADDR_FLAGS)
      begin
         flags <= wr.wdata[2:0];
      end
   end

endmodule // cfa_core

// ### rtl/cfa_dmem.sv
// Banked data RAM with registered read data
`timescale 1ns/100ps
module cfa_dmem
   import cfa_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic we,
   input wire logic [DM_AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Not reset: data RAM holds whatever was left at power-up
   logic [7:0] mem [0:(1<<DM_AW)-1];

   // Write port
   always_ff @(posedge pclk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
   end

   // Registered read, one cycle after the address
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdata <= 8'h00;
      end
      else
      begin
         rdata <= mem[addr];
      end
   end

endmodule // cfa_dmem

// ### rtl/cfa_pkg.sv
// Shared constants and types for the core fetch and bank addressing block
package cfa_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int PC_W = 21;            // Program counter width
   localparam int IW = 16;              // Instruction word width
   localparam int DA_W = 12;            // Data memory address width
   localparam int BANK_W = 4;           // Bank number width
   localparam int OFS_W = 8;            // Offset within a bank
   localparam int DM_AW = 9;            // Implemented RAM address width
   localparam logic [BANK_W-1:0] DM_BANKS = 4'h2; // Banks backed by RAM

   // ----------------------------------------------------------------
   // Program counter and access bank map
   // ----------------------------------------------------------------
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
   localparam logic [OFS_W-1:0] ACCESS_SPLIT = 8'h60;
   localparam logic [BANK_W-1:0] BANK_LOW = 4'h0;
   localparam logic [BANK_W-1:0] BANK_TOP = 4'hF;

   // ----------------------------------------------------------------
   // Core registers seen in data space
   // ----------------------------------------------------------------
   localparam logic [DA_W-1:0] ADDR_PCL = 12'hFF9;
   localparam logic [DA_W-1:0] ADDR_WREG = 12'hFE8;
   localparam logic [DA_W-1:0] ADDR_BANK = 12'hFE0;
   localparam logic [DA_W-1:0] ADDR_FLAGS = 12'hFD8;
   localparam int FLAG_C = 0;           // Carry out of an add
   localparam int FLAG_Z = 1;           // Result zero
   localparam int FLAG_N = 2;           // Result bit 7

   // ----------------------------------------------------------------
   // Opcode fields
   // ----------------------------------------------------------------
   localparam logic [3:0] TWO_WORD_TAG = 4'hF;
   localparam logic [7:0] OP_GOTO = 8'hEF;
   localparam logic [6:0] OP_CALL = 7'h76;
   localparam logic [9:0] OP_LFSR = 10'h3B8;
   localparam logic [3:0] OP_FULL_MOVE = 4'hC;
   localparam logic [4:0] OP_BRA = 5'h1A;
   localparam logic [11:0] OP_BANK_LIT = 12'h010;
   localparam logic [7:0] OP_MOVLW = 8'h0E;
   localparam logic [5:0] OP_ADDWF = 6'h09;
   localparam logic [6:0] OP_MOVWF = 7'h37;

   // ----------------------------------------------------------------
   // APB register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PC = 8'h04;
   localparam logic [7:0] REG_BANK = 8'h08;
   localparam logic [7:0] REG_WREG = 8'h0C;
   localparam logic [7:0] REG_FLAGS = 8'h10;
   localparam logic [7:0] REG_DADDR = 8'h14;
   localparam int CTRL_RUN = 0;
   localparam logic CTRL_RUN_RESET = 1'b0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b10,
      PH_Q4 = 2'b11
   } cfa_phase_e;

   typedef enum logic [1:0] {
      PEND_NONE = 2'b00,
      PEND_GOTO = 2'b01,
      PEND_FULL_MOVE = 2'b10,
      PEND_LFSR = 2'b11
   } cfa_pend_e;

   typedef enum logic [3:0] {
      OPK_NOP = 4'b0000,
      OPK_GOTO1 = 4'b0001,
      OPK_GOTO2 = 4'b0010,
      OPK_FULL_MOVE1 = 4'b0011,
      OPK_FULL_MOVE2 = 4'b0100,
      OPK_LFSR1 = 4'b0101,
      OPK_LFSR2 = 4'b0110,
      OPK_BRA = 4'b0111,
      OPK_BANK_LIT = 4'b1000,
      OPK_MOVLW = 4'b1001,
      OPK_ADDWF = 4'b1010,
      OPK_MOVWF = 4'b1011
   } cfa_op_e;

   // Data memory request carried from decode to the write port
   typedef struct packed {
      logic we;
      logic [DA_W-1:0] addr;
      logic [7:0] wdata;
   } cfa_dm_req_s;

endpackage

// ### testbench/cfa_pmem.sv
// Program memory model, combinational word read
`timescale 1ns/100ps
module cfa_pmem
   import cfa_pkg::*;
(
   input wire logic [PC_W-1:0] pm_addr,
   output logic [IW-1:0] pm_rdata
);
   // Sixty-four words, loaded by the bench
   logic [IW-1:0] mem [0:63];
   // word at even byte address
   // Outside the array a lone tagged word, never a stale value
   assign pm_rdata = (pm_addr[PC_W-1:7] == '0) ? mem[pm_addr[6:1]] : 16'hFFFF;
endmodule // cfa_pmem

// ### testbench/cfa_props.sv
// Port-level checker for the core fetch and bank addressing block
`timescale 1ns/100ps
module cfa_props
   import cfa_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [PC_W-1:0] pm_addr
);
   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed access, and completed read
   wire logic done = psel && penable && pready;
   wire logic rd_ok = done && !pwrite;
   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   property p_pm_even;
      !pm_addr[0];
   endproperty
   // Fetch address holds at least two cycles; a taken jump
   // can move it again three cycles after the Q1 step
   property p_pm_hold;
      $changed(pm_addr) |=> $stable(pm_addr)[*2];
   endproperty
   property p_pc_read;
      rd_ok && paddr == REG_PC |-> prdata[0] == 1'b0 && prdata[31:21] == '0;
   endproperty
   property p_bank_upper;
      rd_ok && paddr == REG_BANK |-> prdata[31:4] == '0;
   endproperty
   property p_unmapped;
      done && paddr > 8'h14 |-> pslverr && prdata == '0;
   endproperty
   property p_daddr;
      rd_ok && paddr == REG_DADDR |-> prdata[31:12] == '0;
   endproperty
   // Answer comes one cycle into the access phase
   property p_ready_time;
      psel && penable && !pready |=> pready;
   endproperty
   property p_err_pulse;
      pslverr |-> pready ##1 !pready;
   endproperty
   a_pm_even: assert property (p_pm_even)
      else $error("pm_addr odd");
   a_pm_hold: assert property (p_pm_hold)
      else $error("pm_addr moved early");
   a_pc_read: assert property (p_pc_read)
      else $error("pc read wrong width");
   a_bank_upper: assert property (p_bank_upper)
      else $error("bank_pointer upper bits set");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not zero");
   a_daddr: assert property (p_daddr)
      else $error("data address too wide");
   a_ready_time: assert property (p_ready_time)
      else $error("pready late");
   a_err_pulse: assert property (p_err_pulse)
      else $error("pslverr without pready");
   c_bank_rd: cover property (rd_ok && paddr == REG_BANK);
   c_unmapped: cover property (done && pslverr);
   c_pm_move: cover property ($changed(pm_addr));
endmodule // cfa_props

// ### testbench/testbench.sv
// Self-checking bench for the core fetch and bank addressing block
`timescale 1ns/100ps
module testbench
   import cfa_pkg::*;
;
   // ------------------------------------------------
   // Signals
   // ------------------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [PC_W-1:0] pm_addr;
   logic [IW-1:0] pm_rdata;
   logic [31:0] rd; // Read data taken
   logic er; // Error taken
   logic [31:0] r; // Random word
   logic [7:0] ua; // Unmapped address
   int seed = 32'h3381800F;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   always #20 pclk = ~pclk;
   cfa_core cfa_core_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pm_addr(pm_addr), .pm_rdata(pm_rdata));
   cfa_pmem cfa_pmem_i (.pm_addr(pm_addr), .pm_rdata(pm_rdata));
   // ------------------------------------------------
   // Tasks and expectations
   // ------------------------------------------------
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] bank_rb(logic [31:0] v);
      return {28'h0000000, v[3:0]};
   endfunction
   // Final loop sits at 54h
   function automatic logic [31:0] in_loop(logic [PC_W-1:0] a);
      return {31'h0, a === 21'h000054 || a === 21'h000056};
   endfunction
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Hang guard, run needs well under a thousand cycles
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_fail++;
         end_of_test;
      end
   end
   // ------------------------------------------------
   // Sequence
   // ------------------------------------------------
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk("pm_addr reset", 32'h0, {11'h000, pm_addr});
      apb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      // Random register traffic, core stopped
      for (int i = 0; i < 8; i++)
      begin
         r = $random(seed);
         ua = 8'h18 + {2'b00, r[5:2], 2'b00};
         apb(1'b1, REG_BANK, r);
         apb(1'b0, REG_BANK, 32'h0);
         chk("bank_pointer", bank_rb(r), rd);
         apb(1'b1, REG_WREG, ~r);
         apb(1'b0, REG_WREG, 32'h0);
         chk("wreg", {24'h000000, ~r[7:0]}, rd);
         apb(1'b0, ua, r);
         chk("unmapped data", 32'h0, rd);
         chk("unmapped error", 32'h1, {31'h0, er});
      end
      $display("test registers done");
      // Program: stores, moves, lone tag, jumps, PC low write
      cfa_pmem_i.mem = '{0: 16'h0E55, 1: 16'h6E20, 2: 16'h0101, 3: 16'h6F30,
         4: 16'hF123, 5: 16'h0E01, 6: 16'h0100, 7: 16'hC130, 8: 16'hFFE8,
         9: 16'h2420, 10: 16'h6E21, 11: 16'h0E00, 12: 16'h0105,
         13: 16'h2710, 14: 16'hEF20, 15: 16'hF000, 16: 16'h0EEE,
         32: 16'hD001, 33: 16'h0EEE, 34: 16'h0E0F, 35: 16'h6EE0,
         36: 16'h0E50, 37: 16'h6FF9, 38: 16'h0EEE, 40: 16'hC021,
         41: 16'hFFE8, 42: 16'hD7FF, default: 16'h0000};
      apb(1'b1, REG_CTRL, 32'h1);
      repeat (400) @(posedge pclk);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge pclk);
         chk("pm loop", 32'h1, in_loop(pm_addr));
      end
      apb(1'b1, REG_CTRL, 32'h0);
      apb(1'b0, REG_WREG, 32'h0);
      chk("wreg sum", 32'h000000AA, rd);
      apb(1'b0, REG_BANK, 32'h0);
      chk("bank via map", {28'h0, BANK_TOP}, rd);
      apb(1'b0, REG_FLAGS, 32'h0);
      chk("flags", 32'h1 << FLAG_Z, rd);
      // Stopped inside the final loop, last data access was the move
      apb(1'b0, REG_PC, 32'h0);
      chk("pc in loop", 32'h1, in_loop(rd[PC_W-1:0]));
      apb(1'b0, REG_DADDR, 32'h0);
      chk("last data address", {20'h0, ADDR_WREG}, rd);
      $display("test program done");
      end_of_test;
   end
endmodule // testbench
bind cfa_core cfa_props cfa_props_i (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pm_addr(pm_addr));
